/* sptfc_pkg.sv */
// constants shared by the spi target flow-control block
`default_nettype none

package sptfc_pkg;

    // -------------------------------------------------------------------
    // fifo geometry
    // -------------------------------------------------------------------
    localparam int         FIFO_DEPTH   = 16;
    localparam int         CNT_W        = 5;
    localparam int         PTR_W        = 4;
    localparam logic [4:0] FIFO_FULL    = 5'h10;
    localparam logic [4:0] CNT_RST      = 5'h00;
    localparam logic [3:0] PTR_RST      = 4'h0;

    // -------------------------------------------------------------------
    // header bytes
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_READ     = 8'h81;
    localparam logic [7:0] CMD_WRITE    = 8'h42;
    localparam logic [7:0] STATUS_READY = 8'hc0;
    localparam logic [7:0] STATUS_BUSY  = 8'h00;
    localparam logic [7:0] FILL_BYTE    = 8'h00;
    localparam logic [7:0] BYTE_RST     = 8'h00;

    // -------------------------------------------------------------------
    // link timing
    // -------------------------------------------------------------------
    localparam int         SYS_CLK_HZ   = 20_000_000;
    localparam int         SCK_MAX_HZ   = 16_000_000;
    localparam int         T_RDY_NS     = 100;
    localparam int         T_RDY_CYC    =
        (T_RDY_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

    // byte position inside a transaction
    typedef enum logic [1:0] {
        SPTFC_HDR_CMD,
        SPTFC_HDR_CAP,
        SPTFC_DATA
    } sptfc_phase_t;

endpackage : sptfc_pkg

`default_nettype wire

/* sptfc_target.sv */
// spi target port with rx/tx fifos, header exchange and ready flow control
`default_nettype none


module sptfc_target
    import sptfc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        spi_sck,
    input  wire logic        spi_csn_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe_n,
    output logic             spi_rdy,
    input  wire logic        cfg_enable,
    input  wire logic        cfg_cpol,
    input  wire logic        cfg_cpha,
    input  wire logic        cfg_lsb_first,
    input  wire logic        cfg_full_duplex,
    input  wire logic        cfg_flow_ctrl,
    input  wire logic        sys_awake,
    input  wire logic [4:0]  tx_limit,
    input  wire logic [4:0]  rx_limit,
    input  wire logic        tx_flush,
    input  wire logic        rx_flush,
    input  wire logic        cpu_wr,
    input  wire logic [2:0]  cpu_wr_bytes,
    input  wire logic [31:0] cpu_wr_data,
    input  wire logic        cpu_rd,
    input  wire logic [2:0]  cpu_rd_bytes,
    output logic [31:0]      cpu_rd_data,
    output logic [4:0]       tx_level,
    output logic [4:0]       rx_level,
    output logic             tx_empty,
    output logic             tx_below_limit,
    output logic             rx_above_limit,
    output logic             rx_full,
    output logic             irq_tx,
    output logic             irq_rx,
    output logic             irq_err
);

    // -------------------------------------------------------------------
    // link domain: effective clock and reset
    // -------------------------------------------------------------------
    logic        lk_clk;
    logic        lk_rst_n;
    // fold polarity and phase so the sampling edge is always rising
    assign lk_clk   = spi_sck ^ cfg_cpol ^ cfg_cpha;
    // chip select high resets the link bit, phase, shifters and header, ending any transaction; the hand-over toggles keep their state
    assign lk_rst_n = nrst & ~spi_csn_n;

    logic [2:0]   lk_bit_reg;
    sptfc_phase_t lk_phase_reg;
    logic [7:0]   lk_cmd_reg;
    logic [7:0]   lk_rxsh_reg;
    logic [7:0]   lk_txsh_reg;
    logic [7:0]   lk_rxbyte_reg;
    logic         lk_rxtgl_reg;
    logic         lk_taketgl_reg;
    logic         lk_hdr_reg;

    // values owned by the system domain; the caps are stable in a frame, hold_reg is refilled after a take while the tx fifo holds bytes
    logic [7:0]   hold_reg;
    logic [4:0]   cap_rx_reg;
    logic [4:0]   cap_tx_reg;

    logic [2:0]   lk_idx;
    logic [7:0]   lk_rx_full;
    logic [7:0]   lk_status;
    logic [7:0]   lk_cur;
    logic         lk_byte_end;
    logic         lk_is_write;
    logic         lk_new_wr;
    logic         lk_rx_data;
    logic         lk_tx_data;
    logic [7:0]   lk_cap;

    // bit select, received byte and header decode
    assign lk_idx      = cfg_lsb_first ? lk_bit_reg : 3'h7 - lk_bit_reg;
    assign lk_byte_end = (lk_bit_reg == 3'h7);
    always_comb begin
        lk_rx_full         = lk_rxsh_reg;
        lk_rx_full[lk_idx] = spi_mosi;
    end
    assign lk_status   = cfg_enable ? STATUS_READY
                                    : STATUS_BUSY;
    assign lk_new_wr   = (lk_rx_full == CMD_WRITE);
    assign lk_is_write = (lk_cmd_reg == CMD_WRITE);
    assign lk_cap      = {3'h0, lk_new_wr ? cap_rx_reg : cap_tx_reg};
    assign lk_rx_data  = cfg_full_duplex | lk_is_write;
    assign lk_tx_data  = cfg_full_duplex | (lk_cmd_reg == CMD_READ);
    assign lk_cur      = (lk_phase_reg == SPTFC_HDR_CMD) ? lk_status
                                                         : lk_txsh_reg;
    assign spi_miso      = lk_cur[lk_idx];
    assign spi_miso_oe_n = spi_csn_n;

    // bit and byte position; multi-byte frames while select is low
    always_ff @(posedge lk_clk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_bit_reg   <= 3'h0;
            lk_phase_reg <= SPTFC_HDR_CMD;
        end else begin
            lk_bit_reg <= lk_bit_reg + 3'h1;
            if (lk_byte_end && lk_phase_reg != SPTFC_DATA)
                lk_phase_reg <= (lk_phase_reg == SPTFC_HDR_CMD)
                              ? SPTFC_HDR_CAP : SPTFC_DATA;
        end
    end

    // receive shift and command capture
    always_ff @(posedge lk_clk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_rxsh_reg <= BYTE_RST;
            lk_cmd_reg  <= BYTE_RST;
            lk_hdr_reg  <= 1'b0;
        end else begin
            lk_rxsh_reg <= lk_byte_end ? BYTE_RST : lk_rx_full;
            if (lk_byte_end && lk_phase_reg == SPTFC_HDR_CMD) begin
                lk_cmd_reg <= lk_rx_full;
                lk_hdr_reg <= 1'b1;
            end
        end
    end

    // next outgoing byte loaded on the sampling edge itself
    always_ff @(posedge lk_clk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_txsh_reg <= FILL_BYTE;
        end else if (lk_byte_end) begin
            if (lk_phase_reg == SPTFC_HDR_CMD) begin
                lk_txsh_reg <= lk_cap;
            end else if (lk_tx_data) begin
                lk_txsh_reg <= hold_reg;
            end else begin
                lk_txsh_reg <= FILL_BYTE;
            end
        end
    end

    // take toggle survives deselect, so no false take follows a frame
    always_ff @(posedge lk_clk or negedge nrst) begin
        if (!nrst) begin
            lk_taketgl_reg <= 1'b0;
        end else if (lk_byte_end && lk_tx_data
                     && lk_phase_reg != SPTFC_HDR_CMD) begin
            lk_taketgl_reg <= ~lk_taketgl_reg;
        end
    end

    // received data byte handed over by toggle; held for a whole byte
    always_ff @(posedge lk_clk or negedge nrst) begin
        if (!nrst) begin
            lk_rxbyte_reg <= BYTE_RST;
            lk_rxtgl_reg  <= 1'b0;
        end else if (lk_byte_end && lk_phase_reg == SPTFC_DATA
                     && lk_rx_data) begin
            lk_rxbyte_reg <= lk_rx_full;
            lk_rxtgl_reg  <= ~lk_rxtgl_reg;
        end
    end

    // -------------------------------------------------------------------
    // system domain: synchronisers
    // -------------------------------------------------------------------
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [1:0] tgl_prev_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg       <= 4'h1;
            s2_reg       <= 4'h1;
            tgl_prev_reg <= 2'h0;
        end else begin
            s1_reg       <= {lk_hdr_reg, lk_taketgl_reg, lk_rxtgl_reg,
                             spi_csn_n};
            s2_reg       <= s1_reg;
            tgl_prev_reg <= s2_reg[2:1];
        end
    end

    logic csn_low;
    logic rx_push;
    logic tx_take;
    logic hdr_seen;
    logic cmd_write;
    assign csn_low   = ~s2_reg[0];
    assign rx_push   = s2_reg[1] ^ tgl_prev_reg[0];
    assign tx_take   = s2_reg[2] ^ tgl_prev_reg[1];
    assign hdr_seen  = s2_reg[3];
    assign cmd_write = (lk_cmd_reg == CMD_WRITE); // stable once hdr_seen

    // -------------------------------------------------------------------
    // fifos
    // -------------------------------------------------------------------
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [3:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
    logic [4:0] rx_cnt_reg, tx_cnt_reg;
    logic       hold_valid_reg;

    logic       rx_wr_ok;
    logic [4:0] rx_pop_n;
    logic [4:0] tx_free;
    logic [4:0] tx_push_n;
    logic       tx_refill;
    logic [31:0] rd_word;

    // byte counts clamp to what the fifo holds or has room for
    assign rx_wr_ok  = rx_push && rx_cnt_reg != FIFO_FULL;
    assign rx_pop_n  = !cpu_rd ? CNT_RST
                     : ({2'h0, cpu_rd_bytes} > rx_cnt_reg) ? rx_cnt_reg
                     : {2'h0, cpu_rd_bytes};
    assign tx_free   = FIFO_FULL - tx_cnt_reg;
    assign tx_push_n = !cpu_wr ? CNT_RST
                     : ({2'h0, cpu_wr_bytes} > tx_free) ? tx_free
                     : {2'h0, cpu_wr_bytes};
    assign tx_refill = !hold_valid_reg && tx_cnt_reg != CNT_RST
                       && !tx_take && !tx_flush;

    // read word: lane k holds the k-th oldest byte
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_lane
            assign rd_word[8*k +: 8] = (5'(k) < rx_pop_n)
                ? rx_mem[rx_rp_reg + 4'(k)] : BYTE_RST;
        end
    endgenerate

    // memory writes
    always_ff @(posedge ref_clk) begin
        if (rx_wr_ok)
            rx_mem[rx_wp_reg] <= lk_rxbyte_reg;
        for (int i = 0; i < 4; i++)
            if (5'(i) < tx_push_n)
                tx_mem[tx_wp_reg + 4'(i)] <= cpu_wr_data[8*i +: 8];
    end

    // rx pointers and count; flush discards everything
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_wp_reg  <= PTR_RST;
            rx_rp_reg  <= PTR_RST;
            rx_cnt_reg <= CNT_RST;
        end else if (rx_flush) begin
            rx_wp_reg  <= PTR_RST;
            rx_rp_reg  <= PTR_RST;
            rx_cnt_reg <= CNT_RST;
        end else begin
            rx_wp_reg  <= rx_wp_reg + {3'h0, rx_wr_ok};
            rx_rp_reg  <= rx_rp_reg + rx_pop_n[3:0];
            rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_wr_ok} - rx_pop_n;
        end
    end

    // tx pointers, count and the hold byte offered to the link
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_wp_reg      <= PTR_RST;
            tx_rp_reg      <= PTR_RST;
            tx_cnt_reg     <= CNT_RST;
            hold_valid_reg <= 1'b0;
            hold_reg       <= BYTE_RST;
        end else if (tx_flush) begin
            tx_wp_reg      <= PTR_RST;
            tx_rp_reg      <= PTR_RST;
            tx_cnt_reg     <= CNT_RST;
            hold_valid_reg <= 1'b0;
        end else begin
            tx_wp_reg  <= tx_wp_reg + tx_push_n[3:0];
            tx_rp_reg  <= tx_rp_reg + {3'h0, tx_refill};
            tx_cnt_reg <= tx_cnt_reg + tx_push_n - {4'h0, tx_refill};
            if (tx_take)
                hold_valid_reg <= 1'b0;
            else if (tx_refill) begin
                hold_valid_reg <= 1'b1;
                hold_reg       <= tx_mem[tx_rp_reg];
            end
        end
    end

    // -------------------------------------------------------------------
    // capacity snapshot, ready line, cpu data and events
    // -------------------------------------------------------------------
    logic [4:0] tx_avail;
    logic       snap_ok_reg;
    logic       rdy_next;
    logic       rdy_reg;
    logic       sh_valid_reg; // byte now in the link shifter is real data
    logic       ev_sent_reg, ev_rcvd_reg, ev_udf_reg, ev_ovf_reg;

    assign tx_avail = tx_cnt_reg + {4'h0, hold_valid_reg};

    // frozen while selected so the count is constant in a transaction
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cap_rx_reg  <= CNT_RST;
            cap_tx_reg  <= CNT_RST;
            snap_ok_reg <= 1'b0;
        end else if (!csn_low) begin
            snap_ok_reg <= 1'b0;
        end else if (!snap_ok_reg) begin
            cap_rx_reg  <= FIFO_FULL - rx_cnt_reg;
            cap_tx_reg  <= (tx_avail > FIFO_FULL) ? FIFO_FULL : tx_avail;
            snap_ok_reg <= 1'b1;
        end
    end

    // ready meaning depends on the phase of the frame
    always_comb begin
        if (!csn_low)
            rdy_next = tx_avail != CNT_RST;
        else if (!hdr_seen)
            rdy_next = cfg_enable && sys_awake && snap_ok_reg;
        else if (!cfg_flow_ctrl || cfg_full_duplex)
            rdy_next = 1'b1;
        else if (cmd_write)
            rdy_next = rx_cnt_reg < FIFO_FULL - 5'h1;
        else
            rdy_next = sh_valid_reg;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdy_reg     <= 1'b0;
            sh_valid_reg <= 1'b1;
            cpu_rd_data <= 32'h0000_0000;
            ev_sent_reg <= 1'b0;
            ev_rcvd_reg <= 1'b0;
            ev_udf_reg  <= 1'b0;
            ev_ovf_reg  <= 1'b0;
        end else begin
            rdy_reg     <= rdy_next;
            // a take moves the hold byte into the shifter for the next byte
            if (!csn_low)
                sh_valid_reg <= 1'b1;
            else if (tx_take)
                sh_valid_reg <= hold_valid_reg;
            if (cpu_rd)
                cpu_rd_data <= rd_word;
            ev_sent_reg <= tx_take && hold_valid_reg;
            ev_rcvd_reg <= rx_wr_ok;
            ev_udf_reg  <= tx_take && !sh_valid_reg; // stale byte shifted
            ev_ovf_reg  <= rx_push && !rx_wr_ok;
        end
    end

    // status flags and the three grouped interrupt lines
    assign spi_rdy        = rdy_reg;
    assign tx_level       = tx_cnt_reg;
    assign rx_level       = rx_cnt_reg;
    assign tx_empty       = tx_cnt_reg == CNT_RST;
    assign tx_below_limit = tx_cnt_reg < tx_limit;
    assign rx_above_limit = rx_cnt_reg > rx_limit;
    assign rx_full        = rx_cnt_reg == FIFO_FULL;
    assign irq_tx = ev_sent_reg | tx_empty | tx_below_limit;
    assign irq_rx = ev_rcvd_reg | rx_full | rx_above_limit;
    assign irq_err = ev_udf_reg | ev_ovf_reg;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    property p_depth;
        @(posedge ref_clk) disable iff (!nrst)
        rx_cnt_reg <= FIFO_FULL && tx_cnt_reg <= FIFO_FULL;
    endproperty
    a_depth: assert property (p_depth)
        else $error("fifo count above depth");

    property p_idle_rdy;
        @(posedge ref_clk) disable iff (!nrst)
        (!csn_low && tx_avail != CNT_RST) |=> spi_rdy;
    endproperty
    a_idle_rdy: assert property (p_idle_rdy)
        else $error("ready low with data waiting");

    property p_wake_hold;
        @(posedge ref_clk) disable iff (!nrst)
        (csn_low && !hdr_seen && !sys_awake) |=> !spi_rdy;
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("ready high while asleep");

    property p_cap_stable;
        @(posedge ref_clk) disable iff (!nrst)
        (snap_ok_reg && csn_low) ##1 csn_low |->
            $stable(cap_rx_reg) && $stable(cap_tx_reg);
    endproperty
    a_cap_stable: assert property (p_cap_stable)
        else $error("capacity changed inside a frame");

    property p_cap_bound;
        @(posedge ref_clk) disable iff (!nrst)
        cap_rx_reg <= FIFO_FULL && cap_tx_reg <= FIFO_FULL;
    endproperty
    a_cap_bound: assert property (p_cap_bound)
        else $error("capacity above sixteen");

    property p_flush;
        @(posedge ref_clk) disable iff (!nrst)
        rx_flush |=> rx_cnt_reg == CNT_RST;
    endproperty
    a_flush: assert property (p_flush)
        else $error("rx flush left bytes");

    property p_ovf;
        @(posedge ref_clk) disable iff (!nrst)
        (rx_push && rx_full) |=> irq_err ##1 !ev_ovf_reg;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not flagged for one cycle");

    property p_rd_count;
        @(posedge ref_clk) disable iff (!nrst)
        (cpu_rd && !rx_push && !rx_flush && rx_cnt_reg >= 5'h4
         && cpu_rd_bytes == 3'h4) |=> rx_cnt_reg == $past(rx_cnt_reg) - 5'h4;
    endproperty
    a_rd_count: assert property (p_rd_count)
        else $error("four-byte read did not take four");

    property p_fc_off;
        @(posedge ref_clk) disable iff (!nrst)
        (csn_low && hdr_seen && !cfg_flow_ctrl) |=> spi_rdy;
    endproperty
    a_fc_off: assert property (p_fc_off)
        else $error("ready low with flow control off");

    property p_status;
        @(posedge lk_clk) disable iff (!lk_rst_n)
        (lk_phase_reg == SPTFC_HDR_CMD && cfg_enable)
            |-> lk_cur == STATUS_READY;
    endproperty
    a_status: assert property (p_status)
        else $error("status byte not ready value");

    c_write: cover property (@(posedge ref_clk) rx_wr_ok && csn_low);
    c_read: cover property (@(posedge ref_clk) ev_sent_reg);
    c_poll: cover property (@(posedge ref_clk)
        hdr_seen && !csn_low ##1 !hdr_seen);
    c_udf: cover property (@(posedge ref_clk) ev_udf_reg);

endmodule : sptfc_target

`default_nettype wire

/* sptfc_host.sv */
// spi controller model that drives the target's link pins in any mode
`default_nettype none
module sptfc_host (
    output logic      spi_sck,
    output logic      spi_csn_n,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n,
    input  wire logic spi_rdy,
    input  wire logic cfg_cpol,
    input  wire logic cfg_cpha
);
    timeunit 1ns;
    timeprecision 100ps;
    int to_cnt = 0; // ready waits that ran out

    // a released miso reads as the pull-up level
    wire logic miso_seen = spi_miso_oe_n ? 1'b1 : spi_miso;

    // link clock stands still while idle
    initial begin
        spi_sck = 1'b0;
        spi_csn_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // wait for ready high under a bound
    task automatic wait_rdy();
        int n;
        n = 0;
        while (spi_rdy !== 1'b1 && n < 400) begin
            #10 n++;
        end
        if (n >= 400) to_cnt++;
    endtask : wait_rdy

    // select, then let the ready line settle before looking at it
    task automatic sel();
        spi_sck = cfg_cpol; // idle level of the chosen mode
        #10 spi_csn_n = 1'b0;
        #200;
    endtask : sel

    // release select; early release is legal
    task automatic desel();
        #20 spi_csn_n = 1'b1;
        #300;
    endtask : desel

    // one byte: wait ready, drive mosi, read the target bit just before the sampling edge
    task automatic xbyte(input logic [7:0] tx, input logic lsb,
                         output logic [7:0] rx);
        int k;
        wait_rdy();
        for (int i = 0; i < 8; i++) begin
            k = lsb ? i : 7 - i;
            if (cfg_cpha)
                spi_sck = ~spi_sck; // leading edge shifts
            spi_mosi = tx[k];
            #7.5 rx[k] = miso_seen;
            spi_sck = ~spi_sck; // sampling edge
            #7.5;
            if (!cfg_cpha)
                spi_sck = ~spi_sck;
        end
        #250; // ready lags the byte end
    endtask : xbyte
endmodule : sptfc_host
`default_nettype wire

/* tb.sv */
// self-checking bench for the spi target flow-control block
`default_nettype none
module tb
    import sptfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0, nrst = 1'b0, cfg_lsb_first = 1'b0;
    logic        cfg_flow_ctrl = 1'b1, tx_flush = 1'b0, rx_flush = 1'b0;
    logic        cfg_cpol = 1'b0, cfg_cpha = 1'b0, sys_awake = 1'b1;
    logic        cpu_wr = 1'b0, cpu_rd = 1'b0;
    logic [2:0]  cpu_wr_bytes = 3'h1, cpu_rd_bytes = 3'h1;
    logic [4:0]  tx_limit = 5'h04, rx_limit = 5'h02, tx_level, rx_level;
    logic [31:0] cpu_wr_data = 32'h0, cpu_rd_data;
    logic        spi_sck, spi_csn_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic        spi_rdy, tx_empty, tx_below_limit, rx_above_limit;
    logic        rx_full, irq_tx, irq_rx, irq_err;
    logic [7:0]  b, q[$];
    int          failures = 0, total_checks = 0, nt;

    sptfc_target dut (
        .ref_clk, .nrst, .spi_sck, .spi_csn_n, .spi_mosi, .spi_miso,
        .spi_miso_oe_n, .spi_rdy, .cfg_enable(1'b1), .cfg_cpol,
        .cfg_cpha, .cfg_lsb_first, .cfg_full_duplex(1'b0),
        .cfg_flow_ctrl, .sys_awake, .tx_limit, .rx_limit, .tx_flush,
        .rx_flush, .cpu_wr, .cpu_wr_bytes, .cpu_wr_data, .cpu_rd,
        .cpu_rd_bytes, .cpu_rd_data, .tx_level, .rx_level, .tx_empty,
        .tx_below_limit, .rx_above_limit, .rx_full, .irq_tx, .irq_rx,
        .irq_err
    );
    sptfc_host u_host (
        .spi_sck, .spi_csn_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .spi_rdy,
        .cfg_cpol, .cfg_cpha
    );

    // 20 MHz system clock
    always #25 ref_clk = ~ref_clk;

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // expected capacity: count clamped to the fifo depth
    function automatic logic [7:0] cap_of(input int n);
        return 8'((n > FIFO_DEPTH) ? FIFO_DEPTH : n);
    endfunction : cap_of

    // cpu write of n random bytes, lane 0 oldest
    task automatic cpu_put(input int n);
        logic [31:0] d;
        d = $urandom;
        for (int i = 0; i < n; i++) q.push_back(d[8*i +: 8]);
        {cpu_wr_bytes, cpu_wr_data, cpu_wr} = {3'(n), d, 1'b1};
        @(posedge ref_clk) #2 cpu_wr = 1'b0;
        @(posedge ref_clk) #2; // strobe stays low a cycle between writes
    endtask : cpu_put

    // cpu read of n bytes; lanes past the count read zero
    task automatic cpu_get(input int n);
        {cpu_rd_bytes, cpu_rd} = {3'(n), 1'b1};
        @(posedge ref_clk) #2 cpu_rd = 1'b0;
        @(posedge ref_clk) #2;
        for (int i = 0; i < 4; i++)
            chk(cpu_rd_data[8*i +: 8], (i < n && q.size() > 0) ?
                q.pop_front() : 8'h00);
    endtask : cpu_get

    // write frame of m bytes; m of zero is a header-only poll
    task automatic wframe(input int m);
        logic [7:0] d;
        {cfg_cpol, cfg_cpha} = 2'($urandom);
        u_host.sel();
        u_host.xbyte(CMD_WRITE, cfg_lsb_first, b);
        chk(b, STATUS_READY);
        u_host.xbyte(FILL_BYTE, cfg_lsb_first, b);
        chk(b, cap_of(FIFO_DEPTH - q.size()));
        repeat (m) begin
            d = $urandom;
            q.push_back(d);
            u_host.xbyte(d, cfg_lsb_first, b);
        end
        u_host.desel();
        @(posedge ref_clk) #2;
    endtask : wframe

    // print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // watchdog far beyond the expected run
    initial begin
        #500_000 failures++;
        summarize();
    end

    // main sequence
    initial begin
        void'($urandom(32'h2bd342ed));
        {tx_limit, rx_limit} = {5'($urandom % 17), 5'($urandom % 8)};
        repeat (5) @(posedge ref_clk);
        #2 nrst = 1'b1;
        repeat (2) @(posedge ref_clk) #2;
        chk(tx_empty, 1'b1);
        chk(spi_rdy, 1'b0);
        while (q.size() < 12) cpu_put(1 + $urandom % 4);
        nt = q.size();
        repeat (6) @(posedge ref_clk) #2;
        chk(tx_level, 8'(nt - 1));
        chk(tx_below_limit, 8'((nt - 1) < tx_limit));
        chk(spi_rdy, 1'b1);
        cfg_lsb_first = 1'($urandom);
        {cfg_cpol, cfg_cpha} = 2'($urandom);
        u_host.sel();
        u_host.xbyte(CMD_READ, cfg_lsb_first, b);
        chk(b, STATUS_READY);
        u_host.xbyte(FILL_BYTE, cfg_lsb_first, b);
        chk(b, cap_of(nt));
        repeat (nt) begin
            u_host.xbyte(FILL_BYTE, cfg_lsb_first, b);
            chk(b, q.pop_front());
        end
        u_host.desel();
        @(posedge ref_clk) #2;
        chk(tx_empty, 1'b1);
        cfg_lsb_first = ~cfg_lsb_first;
        cfg_flow_ctrl = 1'($urandom);
        nt = 2 + $urandom % 9;
        wframe(nt);
        repeat (4) @(posedge ref_clk) #2;
        chk(rx_level, 8'(nt));
        chk(rx_above_limit, 8'(nt > rx_limit));
        chk(rx_full, 1'b0);
        chk({irq_rx, irq_err}, 8'(2 * (nt > rx_limit)));
        // asleep: ready must stay low after select
        sys_awake = 1'b0;
        u_host.sel();
        chk(spi_rdy, 1'b0);
        @(posedge ref_clk) #2 sys_awake = 1'b1;
        u_host.desel();
        @(posedge ref_clk) #2;
        cfg_flow_ctrl = 1'b1;
        wframe(0);
        while (q.size() > 0) cpu_get(1 + $urandom % 4);
        chk(rx_level, 8'h00);
        wframe(3);
        cpu_put(3);
        {tx_flush, rx_flush} = 2'b11;
        @(posedge ref_clk) #2 {tx_flush, rx_flush} = 2'b00;
        repeat (3) @(posedge ref_clk) #2;
        q.delete();
        chk(tx_level, 8'h00);
        chk(rx_level, 8'h00);
        chk({tx_empty, irq_tx}, 8'h03);
        chk(u_host.to_cnt == 0, 1'b1);
        summarize();
    end
endmodule : tb
`default_nettype wire
